// *** sim/ovx_front_model.sv ***
// Voltage front end model: drives two phase samples whose difference is a square wave.
// Assumes the sample tick of the block falls every OVX_SAMPLE_DIV clocks after reset.
`include "ovx_cfg.svh"
module ovx_front_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] amp,
    output logic      [15:0] phase_a,
    output logic      [15:0] phase_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt;
    logic [1:0] step;
    logic       pos;

    // Steps change mid-interval, so a sample is never taken while it moves.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= 0;
            step <= 2'h3;
        end
        else
        begin
            cnt <= (cnt == `OVX_SAMPLE_DIV - 1) ? 0 : cnt + 1;
            if (cnt == `OVX_SAMPLE_DIV / 2 - 1)
                step <= step + 2'h1;
        end
    end

    // Pattern + - - + keeps the integrated flux centred on zero.
    assign pos     = (step == 2'h0) || (step == 2'h3);
    assign phase_a = pos ? amp : -amp;
    assign phase_b = -phase_a;
endmodule

// *** sim/ovx_top_test.sv ***
// Self-checking bench for the overexcitation block, driven through its register port.
// Assumes ovx_cfg.svh register map and a 2 kHz sample tick from the 10 MHz clock.
`include "ovx_cfg.svh"
module ovx_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk;
    logic        rst;
    logic [15:0] amp;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [31:0] rdata;
    logic        warning;
    logic        trip;
    logic        irq;
    int          bad_count;
    int          n_checks;
    int          cyc = 0;
    int          n;
    int          t_warn;
    logic [31:0] v;
    logic [31:0] a1;
    logic [7:0]  adr_tab [14] = '{`OVX_ADR_CTRL, `OVX_ADR_RATED, `OVX_ADR_START, `OVX_ADR_HIGH,
        `OVX_ADR_TMS, `OVX_ADR_MIN, `OVX_ADR_MAX, `OVX_ADR_COOL, `OVX_ADR_STAT, `OVX_ADR_MASK,
        `OVX_ADR_FLUX, `OVX_ADR_RATIO, `OVX_ADR_ACC, 8'h3C};
    logic [31:0] exp_tab [14] = '{{30'h0, `OVX_RST_MODE}, `OVX_RST_RATED, {16'h0, `OVX_RST_START},
        {16'h0, `OVX_RST_HIGH}, {24'h0, `OVX_RST_TMS}, `OVX_RST_MIN_CS, `OVX_RST_MAX_CS,
        `OVX_RST_COOL_CS, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    ovx_front_model front
    (
        .clk     (sys_clk),
        .rst     (rst),
        .amp     (amp),
        .phase_a (phase_a),
        .phase_b (phase_b)
    );

    ovx_top dut
    (
        .SYS_CLK (sys_clk),
        .RST     (rst),
        .PHASE_A (phase_a),
        .PHASE_B (phase_b),
        .ADDR    (addr),
        .WDATA   (wdata),
        .WR      (wr_s),
        .RD      (rd_s),
        .RDATA   (rdata),
        .WARNING (warning),
        .TRIP    (trip),
        .IRQ     (irq)
    );

    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
        cyc <= cyc + 1;

    task automatic test_done;
        $display("Checks made: %0d, mismatches: %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge sys_clk);
        wr_s  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask

    task automatic wait_hi(input bit sel_trip, input int limit, output int cnt);
        cnt = 0;
        while (((sel_trip ? trip : warning) !== 1'b1) && cnt < limit)
        begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    task automatic settle;
        repeat (3) @(negedge sys_clk);
    endtask

    initial
    begin
        // The tests need about eight sample ticks; twelve leave room to spare.
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        $display("CHECK FAILED at %0t: run did not finish in time", $time);
        test_done;
    end

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        amp = 16'h0;
        addr = 8'h0;
        wdata = 32'h0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk({29'h0, warning, trip, irq}, 32'h0, "outputs after reset");
        for (int i = 0; i < 14; i++)
            rchk(adr_tab[i], exp_tab[i], "reset value");
        @(negedge sys_clk);
        chk(rdata, 32'h0, "read data outside read cycle");
        wr(`OVX_ADR_CTRL, 32'h3);
        rchk(`OVX_ADR_CTRL, 32'h0, "mode 3 stored as off");
        wr(`OVX_ADR_TMS, 32'h0);
        rchk(`OVX_ADR_TMS, 32'h1, "multiplier low clamp");
        wr(`OVX_ADR_TMS, 32'h63);
        rchk(`OVX_ADR_TMS, 32'h3C, "multiplier high clamp");
        wr(8'h3C, 32'h5);
        rchk(8'h3C, 32'h0, "unmapped write ignored");
        wr(`OVX_ADR_CTRL, 32'h1);
        // A zero delay setting means one sample tick, which keeps the run short.
        wr(`OVX_ADR_MIN, 32'h0);
        wr(`OVX_ADR_MASK, 32'h3);
        amp <= 16'h1F40;
        // Both flux peaks need about four ticks, so an early start is wrong.
        wait_hi(1'b0, 8 * `OVX_SAMPLE_DIV, n);
        t_warn = cyc;
        chk({31'h0, n >= 3 * `OVX_SAMPLE_DIV}, 32'h1, "start before both peaks");
        chk({31'h0, warning}, 32'h1, "warning on high flux");
        rchk(`OVX_ADR_STAT, 32'h5, "status at start");
        chk({31'h0, irq}, 32'h1, "interrupt on warning");
        chk({31'h0, trip}, 32'h0, "no trip at start");
        rd(`OVX_ADR_RATIO, v);
        chk({31'h0, v > 32'd140}, 32'h1, "ratio above high threshold");
        rd(`OVX_ADR_FLUX, v);
        chk({31'h0, v != 32'h0}, 32'h1, "flux magnitude found");
        wr(`OVX_ADR_MASK, 32'h2);
        settle;
        chk({31'h0, irq}, 32'h0, "masked warning event");
        wr(`OVX_ADR_STAT, 32'h1);
        rchk(`OVX_ADR_STAT, 32'h4, "warning event cleared");
        wr(`OVX_ADR_MASK, 32'h3);
        settle;
        chk({31'h0, irq}, 32'h0, "no pending event");
        wait_hi(1'b1, 3 * `OVX_SAMPLE_DIV, n);
        n = cyc - t_warn;
        chk({31'h0, n > 0 && n <= 2 * `OVX_SAMPLE_DIV}, 32'h1,
            "definite delay length");
        settle;
        chk({30'h0, warning, irq}, 32'h3, "warning and interrupt at trip");
        rchk(`OVX_ADR_STAT, 32'h6, "trip event recorded");
        wr(`OVX_ADR_CTRL, 32'h0);
        settle;
        chk({30'h0, warning, trip}, 32'h0, "off mode silences outputs");
        wr(`OVX_ADR_CTRL, 32'h2);
        repeat (`OVX_SAMPLE_DIV) @(negedge sys_clk);
        rd(`OVX_ADR_ACC, a1);
        repeat (`OVX_SAMPLE_DIV) @(negedge sys_clk);
        rd(`OVX_ADR_ACC, v);
        chk({31'h0, v > a1}, 32'h1, "inverse accumulator grows");
        chk({31'h0, v < `OVX_ACC_ONE}, 32'h1, "inverse accumulator below one");
        chk({30'h0, warning, trip}, 32'h2, "inverse mode started, no trip");
        // A large rated flux drops the ratio below drop-off; a short cooling time empties it.
        wr(`OVX_ADR_COOL, 32'h1);
        wr(`OVX_ADR_RATED, 32'h0001_0000);
        rd(`OVX_ADR_RATIO, v);
        chk(v, (32'h0000_3E80 * `OVX_RATED_PCT) / 32'h0001_0000, "ratio of new rating");
        repeat (`OVX_SAMPLE_DIV) @(negedge sys_clk);
        rchk(`OVX_ADR_ACC, 32'h0, "accumulator cooled to zero");
        test_done;
    end
endmodule

// *** verilog/ovx_cfg.svh ***
// Constants for the overexcitation flux protection block.
// Assumes a 10 MHz system clock and a software register port.
`ifndef OVX_CFG_SVH
`define OVX_CFG_SVH
`define OVX_CLK_HZ        10000000
`define OVX_SAMPLE_HZ     2000
`define OVX_SAMPLE_DIV    (`OVX_CLK_HZ / `OVX_SAMPLE_HZ)
`define OVX_RATED_PCT     100
`define OVX_DROP_NUM      95
`define OVX_DROP_DEN      100
`define OVX_IEEE_K_MILLI  180
`define OVX_TMS_MIN       1
`define OVX_TMS_MAX       60
`define OVX_DROPOFF_MS    60
`define OVX_ACC_ONE       32'h0100_0000
`define OVX_ADR_CTRL      8'h00
`define OVX_ADR_RATED     8'h04
`define OVX_ADR_START     8'h08
`define OVX_ADR_HIGH      8'h0C
`define OVX_ADR_TMS       8'h10
`define OVX_ADR_MIN       8'h14
`define OVX_ADR_MAX       8'h18
`define OVX_ADR_COOL      8'h1C
`define OVX_ADR_STAT      8'h20
`define OVX_ADR_MASK      8'h24
`define OVX_ADR_FLUX      8'h28
`define OVX_ADR_RATIO     8'h2C
`define OVX_ADR_ACC       8'h30
`define OVX_RST_MODE      2'h1
`define OVX_RST_START     16'h006E
`define OVX_RST_HIGH      16'h008C
`define OVX_RST_TMS       8'h0A
`define OVX_RST_MIN_CS    32'h0000_03E8
`define OVX_RST_MAX_CS    32'h0004_93E0
`define OVX_RST_COOL_CS   32'h0001_86A0
`define OVX_RST_RATED     32'h0000_1000
`define OVX_MS_PER_S      1000
`define OVX_CS_PER_S      100
`define OVX_ONE_CS        32'h0000_0001
`define OVX_IRQ_ST        0
`define OVX_IRQ_TR        1
`define OVX_IRQ_MAG       2
`endif

// *** verilog/ovx_pkg.sv ***
// Types for the overexcitation flux protection block.
// Used with ovx_cfg.svh; no imports are made anywhere.
package ovx_pkg;
    typedef enum logic [1:0]
    {
        OVX_OFF  = 2'h0,
        OVX_DEF  = 2'h1,
        OVX_IEEE = 2'h2
    } ovx_mode_e;

    typedef enum logic [1:0]
    {
        OVX_WAIT_FIRST = 2'h0,
        OVX_WAIT_OTHER = 2'h1,
        OVX_VALID      = 2'h3
    } ovx_peak_e;

    typedef struct packed
    {
        logic [15:0] a;
        logic [15:0] b;
    } ovx_phase_s;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ovx_bus_s;
endpackage

// *** verilog/ovx_top.sv ***
// Overexcitation flux protection: integrator, peak finder, U/f grading and timers.
// Assumes phase samples arrive synchronous to SYS_CLK; a sample is taken each sample tick.
`include "ovx_cfg.svh"
module ovx_top
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [15:0] PHASE_A,
    input  wire logic [15:0] PHASE_B,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             WARNING,
    output logic             TRIP,
    output logic             IRQ
);
    localparam logic [31:0] SCALE = 32'h0000_0000 + `OVX_SAMPLE_HZ;
    localparam logic [31:0] DROP_TICKS = (`OVX_DROPOFF_MS * `OVX_SAMPLE_HZ) / `OVX_MS_PER_S;
    localparam logic [31:0] CS_TICKS = `OVX_SAMPLE_HZ / `OVX_CS_PER_S;
    localparam logic [31:0] DIV_LAST = `OVX_SAMPLE_DIV - 1;
    // Converts a centisecond setting to sample ticks, never less than one.
    function automatic logic [31:0] cs_to_ticks(input logic [31:0] cs);
        logic [31:0] t;
        t = cs * CS_TICKS;
        return (t == 32'h0) ? 32'h1 : t;
    endfunction
    ovx_pkg::ovx_phase_s ph;
    ovx_pkg::ovx_bus_s   bus;
    assign ph = '{a: PHASE_A, b: PHASE_B};
    assign bus = '{wr: WR, rd: RD, adr: ADDR, dat: WDATA};
    logic [1:0]  mode_r;
    logic [15:0] start_r;
    logic [15:0] high_r;
    logic [7:0]  tms_r;
    logic [31:0] min_r;
    logic [31:0] max_r;
    logic [31:0] cool_r;
    logic [31:0] rated_r;
    logic [2:0]  stat_r;
    logic [2:0]  mask_r;
    logic [31:0] div_r;
    logic        tick;
    logic signed [31:0] flux_r;
    logic signed [31:0] fmax_r;
    logic signed [31:0] fmin_r;
    logic        rising_r;
    logic        have_pos_r;
    logic        have_neg_r;
    ovx_pkg::ovx_peak_e peak_r;
    logic [31:0] mag_r;
    logic [31:0] ratio_r;
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] dt_r;
    logic [31:0] drop_r;
    logic        started_r;
    logic [2:0]  ev;
    logic [7:0]  tms_nxt;
    logic signed [16:0] line_to_line_sample;
    logic        above;
    logic        below_drop;
    logic [31:0] excess;
    logic [31:0] t_inv;
    logic [31:0] inc;
    logic [31:0] cool_dec;
    // The divider provides the sample rate used by every timer.
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            div_r <= 32'h0;
        else if (div_r == DIV_LAST)
            div_r <= 32'h0;
        else
            div_r <= div_r + 32'h1;
    end
    assign tick = (div_r == DIV_LAST);
    // Raw difference of two phases; drop compensation is deliberately absent.
    assign line_to_line_sample = $signed({ph.a[15], ph.a}) - $signed({ph.b[15], ph.b});
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            flux_r <= 32'sh0;
        else if (tick)
            flux_r <= flux_r + 32'(line_to_line_sample) - (flux_r >>> 12);
    end
    // The small leak keeps a DC offset from walking the integrator into its rail.
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            rising_r   <= 1'b1;
            fmax_r     <= 32'sh0;
            fmin_r     <= 32'sh0;
            have_pos_r <= 1'b0;
            have_neg_r <= 1'b0;
        end
        else if (tick)
        begin
            if (rising_r && line_to_line_sample < 0)
            begin
                fmax_r     <= flux_r;
                have_pos_r <= 1'b1;
                rising_r   <= 1'b0;
            end
            else if (!rising_r && line_to_line_sample > 0)
            begin
                fmin_r     <= flux_r;
                have_neg_r <= 1'b1;
                rising_r   <= 1'b1;
            end
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            peak_r <= ovx_pkg::OVX_WAIT_FIRST;
        else
            case (peak_r)
                ovx_pkg::OVX_WAIT_FIRST:
                    if (have_pos_r || have_neg_r)
                        peak_r <= ovx_pkg::OVX_WAIT_OTHER;
                ovx_pkg::OVX_WAIT_OTHER:
                    if (have_pos_r && have_neg_r)
                        peak_r <= ovx_pkg::OVX_VALID;
                ovx_pkg::OVX_VALID:
                    peak_r <= ovx_pkg::OVX_VALID;
                default:
                    peak_r <= ovx_pkg::OVX_WAIT_FIRST;
            endcase
    end
    // Half peak-to-peak flux, then percent of the rated flux value.
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            mag_r   <= 32'h0;
            ratio_r <= 32'h0;
        end
        else if (peak_r == ovx_pkg::OVX_VALID)
        begin
            mag_r   <= 32'(fmax_r - fmin_r) >> 1;
            ratio_r <= (mag_r * `OVX_RATED_PCT) / ((rated_r == 32'h0) ? 32'h1 : rated_r);
        end
    end
    assign above = (peak_r == ovx_pkg::OVX_VALID) && (ratio_r > 32'(start_r));
    assign below_drop = (ratio_r * `OVX_DROP_DEN) < (32'(start_r) * `OVX_DROP_NUM);
    assign excess = above ? (ratio_r - 32'(start_r)) : 32'h1;
    // Inverse time in ticks: 0.18*TMS/(G-Gs)^2 with G in percent, so *10^4.
    always_comb
    begin
        t_inv = (32'(`OVX_IEEE_K_MILLI) * 32'(tms_r) * 32'd10 * SCALE) / (excess * excess);
        if (t_inv > cs_to_ticks(max_r))
            t_inv = cs_to_ticks(max_r);
        if (ratio_r > 32'(high_r) && t_inv < cs_to_ticks(min_r))
            t_inv = cs_to_ticks(min_r);
        if (t_inv == 32'h0)
            t_inv = 32'h1;
    end
    // Reciprocal of operate time in accumulator units; cooling is the same idea reversed.
    assign inc = `OVX_ACC_ONE / t_inv;
    assign cool_dec = `OVX_ACC_ONE / cs_to_ticks(cool_r);
    always_comb
    begin
        acc_nxt = acc_r;
        if (above)
            acc_nxt = acc_r + inc;
        else if (below_drop)
            acc_nxt = (acc_r > cool_dec) ? acc_r - cool_dec : 32'h0;
    end
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            acc_r  <= 32'h0;
            dt_r   <= 32'h0;
            drop_r <= 32'h0;
        end
        else if (mode_r == ovx_pkg::OVX_OFF)
        begin
            acc_r  <= 32'h0;
            dt_r   <= 32'h0;
            drop_r <= 32'h0;
        end
        else if (tick)
        begin
            if (mode_r == ovx_pkg::OVX_IEEE)
                acc_r <= acc_nxt;
            if (above)
            begin
                dt_r   <= (dt_r < cs_to_ticks(min_r)) ? dt_r + 32'h1 : dt_r;
                drop_r <= 32'h0;
            end
            else if (below_drop && drop_r < DROP_TICKS)
                drop_r <= drop_r + 32'h1;
            else if (below_drop)
                dt_r <= 32'h0;
        end
    end
    // Definite mode holds its start through the hysteresis band until drop-off.
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            started_r <= 1'b0;
            WARNING   <= 1'b0;
            TRIP      <= 1'b0;
        end
        else if (mode_r == ovx_pkg::OVX_OFF)
        begin
            started_r <= 1'b0;
            WARNING   <= 1'b0;
            TRIP      <= 1'b0;
        end
        else
        begin
            started_r <= above || (started_r && !(below_drop && drop_r >= DROP_TICKS));
            WARNING   <= above || started_r;
            if (mode_r == ovx_pkg::OVX_DEF)
                TRIP <= started_r && (dt_r >= cs_to_ticks(min_r));
            else
                TRIP <= started_r && (acc_r >= `OVX_ACC_ONE);
        end
    end
    assign tms_nxt = (bus.dat[7:0] < 8'(`OVX_TMS_MIN)) ? 8'(`OVX_TMS_MIN) :
                     (bus.dat[7:0] > 8'(`OVX_TMS_MAX)) ? 8'(`OVX_TMS_MAX) : bus.dat[7:0];
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            mode_r  <= `OVX_RST_MODE;
            start_r <= `OVX_RST_START;
            high_r  <= `OVX_RST_HIGH;
            tms_r   <= `OVX_RST_TMS;
            min_r   <= `OVX_RST_MIN_CS;
            max_r   <= `OVX_RST_MAX_CS;
            cool_r  <= `OVX_RST_COOL_CS;
            rated_r <= `OVX_RST_RATED;
            mask_r  <= 3'h0;
        end
        else if (bus.wr)
            case (bus.adr)
                `OVX_ADR_CTRL:  mode_r  <= (bus.dat[1:0] == 2'h3) ? 2'h0 : bus.dat[1:0];
                `OVX_ADR_RATED: rated_r <= bus.dat;
                `OVX_ADR_START: start_r <= bus.dat[15:0];
                `OVX_ADR_HIGH:  high_r  <= bus.dat[15:0];
                `OVX_ADR_TMS:   tms_r   <= tms_nxt;
                `OVX_ADR_MIN:   min_r   <= bus.dat;
                `OVX_ADR_MAX:   max_r   <= bus.dat;
                `OVX_ADR_COOL:  cool_r  <= bus.dat;
                `OVX_ADR_MASK:  mask_r  <= bus.dat[2:0];
                default:        mask_r  <= mask_r;
            endcase
    end
    logic warn_q;
    logic trip_q;
    logic valid_q;
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            warn_q  <= 1'b0;
            trip_q  <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            warn_q  <= WARNING;
            trip_q  <= TRIP;
            valid_q <= (peak_r == ovx_pkg::OVX_VALID);
        end
    end
    assign ev[`OVX_IRQ_ST]  = WARNING && !warn_q;
    assign ev[`OVX_IRQ_TR]  = TRIP && !trip_q;
    assign ev[`OVX_IRQ_MAG] = (peak_r == ovx_pkg::OVX_VALID) && !valid_q;
    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            stat_r <= 3'h0;
        else if (bus.wr && bus.adr == `OVX_ADR_STAT)
            stat_r <= (stat_r & ~bus.dat[2:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= |((stat_r | ev) & mask_r);
    end
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            RDATA <= 32'h0;
        else if (bus.rd)
            case (bus.adr)
                `OVX_ADR_CTRL:  RDATA <= {30'h0, mode_r};
                `OVX_ADR_RATED: RDATA <= rated_r;
                `OVX_ADR_START: RDATA <= {16'h0, start_r};
                `OVX_ADR_HIGH:  RDATA <= {16'h0, high_r};
                `OVX_ADR_TMS:   RDATA <= {24'h0, tms_r};
                `OVX_ADR_MIN:   RDATA <= min_r;
                `OVX_ADR_MAX:   RDATA <= max_r;
                `OVX_ADR_COOL:  RDATA <= cool_r;
                `OVX_ADR_STAT:  RDATA <= {29'h0, stat_r};
                `OVX_ADR_MASK:  RDATA <= {29'h0, mask_r};
                `OVX_ADR_FLUX:  RDATA <= mag_r;
                `OVX_ADR_RATIO: RDATA <= ratio_r;
                `OVX_ADR_ACC:   RDATA <= acc_r;
                default:        RDATA <= 32'h0;
            endcase
        else
            RDATA <= 32'h0;
    end
    sequence s_off_written;
        bus.wr && bus.adr == `OVX_ADR_CTRL && bus.dat[1:0] == 2'h0;
    endsequence
    a_off_silences: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_off_written ##2 1'b1 |-> !WARNING && !TRIP)
        else $error("Outputs active while disabled.");
    a_tms_range: assert property (@(posedge SYS_CLK) disable iff (RST)
        tms_r >= 8'(`OVX_TMS_MIN) && tms_r <= 8'(`OVX_TMS_MAX))
        else $error("Time multiplier out of range.");
    a_trip_needs_start: assert property (@(posedge SYS_CLK) disable iff (RST)
        $rose(TRIP) |-> $past(started_r))
        else $error("Trip without start.");
    a_start_needs_valid: assert property (@(posedge SYS_CLK) disable iff (RST)
        WARNING |-> peak_r == ovx_pkg::OVX_VALID)
        else $error("Warning before both peaks.");
    a_warn_follows: assert property (@(posedge SYS_CLK) disable iff (RST)
        above && mode_r != ovx_pkg::OVX_OFF ##1 mode_r != ovx_pkg::OVX_OFF |-> WARNING)
        else $error("Warning missed start.");
    a_def_timer: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode_r == ovx_pkg::OVX_DEF && TRIP |-> $past(dt_r) >= cs_to_ticks($past(min_r)))
        else $error("Definite trip early.");
    a_inv_bounds: assert property (@(posedge SYS_CLK) disable iff (RST)
        t_inv <= cs_to_ticks(max_r) || ratio_r > 32'(high_r))
        else $error("Inverse time above cap.");
    a_cool_down: assert property (@(posedge SYS_CLK) disable iff (RST)
        tick && mode_r == ovx_pkg::OVX_IEEE && !above && below_drop ##1 1'b1
        |-> acc_r <= $past(acc_r))
        else $error("Accumulator grew while cooling.");
endmodule
